//--- rtl/vism_core.sv
// Function
// R1: Core tick on request 0, vector 0
// R2: Soft requests on 1,2, vectors 1,2
// R3: Pin events 3,8,13,18,23 to vectors 3..19
// R4: Timers 4,9,14,19,24 to vectors 4..20
// R5: Capture fault/event pairs share one vector
// R6: Compare events 7..27 to vectors 6..22
// R7: Converter done on 28, vector 23, persistent
// R8: Clock fail monitor on 29, vector 24
// R9: Calendar clock on 30, vector 25
// R10: Flash event on 31, vector 26
// R11: Comparators on 32,33, vectors 27,28
// R12: Combined USB request 34, vector 29, persistent
// R13: Serial port requests 35-37 share vector 30
// R14: Async port requests 38-40 share vector 31
// R15: Two-wire requests 41-43 share vector 32
// R16: Four 8-bit priority slots per register
// R17: Ties go to the lower vector
// R18: Forward only flagged and enabled sources
// R19: Persistent flags re-set while condition holds
// R20: Flags, enables, priorities software read/write
`timescale 1ns/100ps
`default_nettype none
`include "vism_map.svh"

module vism_core
    import vism_pkg::*;
(
    input  wire logic                     ref_clk,
    input  wire logic                     reset_n,
    input  wire logic [`VISM_NUM_SRC-1:0] src_event,
    input  wire logic [7:0]               reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [31:0]                   reg_rdata,
    output logic                          core_irq,
    output logic [5:0]                    core_vector,
    output logic [2:0]                    core_priority,
    output logic [1:0]                    core_subpriority
);

    localparam int NS = `VISM_NUM_SRC;
    localparam int NV = `VISM_NUM_VEC;

    // ****************************************************************
    // Source to vector map
    // ****************************************************************
    // Request number to vector number
    function automatic logic [5:0] src_vec(input int s);
        if (s <= 4)
            return 6'(s);                         // [R1] [R2] [R3] [R4]
        else if (s <= 27)
        begin
            // Group of five per capture channel: pin,timer,fault,cap,cmp
            int g;
            int k;
            g = (s - 3) / 5;
            k = (s - 3) % 5;
            case (k)
                0:       return 6'(3 + 4 * g);    // [R3]
                1:       return 6'(4 + 4 * g);    // [R4]
                2, 3:    return 6'(5 + 4 * g);    // [R5]
                default: return 6'(6 + 4 * g);    // [R6]
            endcase
        end
        else if (s <= 34)
            return 6'(s - 5);        // [R7] [R8] [R9] [R10] [R11] [R12]
        else if (s <= 37)
            return 6'd30;                         // [R13]
        else if (s <= 40)
            return 6'd31;                         // [R14]
        else
            return 6'd32;                         // [R15]
    endfunction

    // Persistent sources: capture pairs, converter, USB, serial, async and two-wire ports
    function automatic logic src_persist(input int s);
        int k;
        k = (s - 3) % 5;
        if (s >= 5 && s <= 27)
            return (k == 2 || k == 3);            // [R5]
        return (s == 28) || (s >= 34);            // [R7] [R12]-[R15]
    endfunction

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic rst_meta_r;
    logic rst_n_r;

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [63:0]                      flags_r;
    logic [63:0]                      enables_r;
    logic [`VISM_NUM_PRIO_REG-1:0][31:0] prio_r;
    logic [63:0]                      flags_nxt;
    logic [63:0]                      ev_set;
    logic [3:0]                       prio_idx;
    logic                             prio_hit;

    assign prio_idx = 4'((reg_addr - `VISM_OFF_PRIO_BASE) >> 2);
    assign prio_hit = reg_addr >= `VISM_OFF_PRIO_BASE
                   && reg_addr <= `VISM_OFF_PRIO_LAST
                   && reg_addr[1:0] == 2'b00;

    // Event edges for plain sources, levels for persistent ones
    logic [NS-1:0] ev_prev_r;

    always_ff @(posedge ref_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            ev_prev_r <= '0;
        else
            ev_prev_r <= src_event;
    end

    always_comb
    begin
        ev_set = '0;
        for (int s = 0; s < NS; s++)
        begin
            if (src_persist(s))
                ev_set[s] = src_event[s];                       // [R19]
            else
                ev_set[s] = src_event[s] & ~ev_prev_r[s];
        end
    end

    // Software write first, hardware set wins over a clear
    always_comb
    begin
        flags_nxt = flags_r;
        if (reg_wr && reg_addr == `VISM_OFF_FLAGS_LOW)
            flags_nxt[31:0] = reg_wdata;                        // [R20]
        if (reg_wr && reg_addr == `VISM_OFF_FLAGS_HIGH)
            flags_nxt[63:32] = {20'h0_0000,
                                reg_wdata[`VISM_HIGH_BITS-1:0]};
        flags_nxt = flags_nxt | ev_set;
    end

    always_ff @(posedge ref_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            flags_r <= {`VISM_FLAGS_RST, `VISM_FLAGS_RST};
        else
            flags_r <= flags_nxt;
    end

    always_ff @(posedge ref_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            enables_r <= {`VISM_ENABLES_RST, `VISM_ENABLES_RST};
        else if (reg_wr && reg_addr == `VISM_OFF_ENABLES_LOW)
            enables_r[31:0] <= reg_wdata;                       // [R20]
        else if (reg_wr && reg_addr == `VISM_OFF_ENABLES_HIGH)
            enables_r[63:32] <= {20'h0_0000,
                                 reg_wdata[`VISM_HIGH_BITS-1:0]};
    end

    // Only the priority and sub-priority fields are kept
    always_ff @(posedge ref_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            prio_r <= '{default: `VISM_PRIO_RST};
        else if (reg_wr && prio_hit)
            prio_r[prio_idx] <= reg_wdata & 32'h1f1f_1f1f;      // [R16]
    end

    // ****************************************************************
    // Arbitration
    // ****************************************************************
    logic [NV-1:0] vec_pend;
    vism_req_s     win;

    always_comb
    begin
        vec_pend = '0;
        for (int s = 0; s < NS; s++)
            if (flags_r[s] && enables_r[s])                     // [R18]
                vec_pend[src_vec(s)] = 1'b1;
    end

    always_comb
    begin
        logic [7:0] slot;
        slot = 8'h00;
        win  = '0;
        for (int v = 0; v < NV; v++)
        begin
            slot = prio_r[v / 4][(v % 4) * `VISM_SLOT_W +: 8];  // [R16]
            // Strictly greater keeps the lower vector on ties
            if (vec_pend[v] && (!win.req
                || slot[4:0] > {win.pri, win.sub}))             // [R17]
            begin
                win.req = 1'b1;
                win.vec = 6'(v);
                win.pri = slot[`VISM_PRI_LSB +: 3];
                win.sub = slot[`VISM_SUB_LSB +: 2];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            core_irq         <= 1'b0;
            core_vector      <= 6'h00;
            core_priority    <= 3'h0;
            core_subpriority <= 2'h0;
        end
        else
        begin
            core_irq         <= win.req;                        // [R18]
            core_vector      <= win.vec;
            core_priority    <= win.pri;
            core_subpriority <= win.sub;
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd)
        begin
            if (reg_addr == `VISM_OFF_FLAGS_LOW)
                reg_rdata <= flags_r[31:0];
            else if (reg_addr == `VISM_OFF_FLAGS_HIGH)
                reg_rdata <= flags_r[63:32];
            else if (reg_addr == `VISM_OFF_ENABLES_LOW)
                reg_rdata <= enables_r[31:0];
            else if (reg_addr == `VISM_OFF_ENABLES_HIGH)
                reg_rdata <= enables_r[63:32];
            else if (prio_hit)
                reg_rdata <= prio_r[prio_idx];
            else if (reg_addr == `VISM_OFF_STATUS)
                reg_rdata <= {16'h0000, 1'b0, win.req, win.vec,
                              3'h0, win.pri, win.sub};
            else
                reg_rdata <= 32'h0000_0000;
        end
        else
            reg_rdata <= 32'h0000_0000;
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n_r);

    tick_vector_a: assert property (                            // [R1]
        flags_r[0] && enables_r[0] && vec_pend == 33'h1
        |=> core_irq && core_vector == 6'd0)
        else $error("core tick not on vector 0");

    sw_set_a: assert property (                                 // [R2]
        reg_wr && reg_addr == `VISM_OFF_FLAGS_LOW && reg_wdata[2]
        |=> flags_r[2])
        else $error("soft request b not raised");

    pin_vec_a: assert property (                                // [R3]
        vec_pend == (33'h1 << 11) |=> core_vector == 6'd11)
        else $error("pin event c vector wrong");

    capture_share_a: assert property (                          // [R5]
        (flags_r[5] & enables_r[5]) || (flags_r[6] & enables_r[6])
        |-> vec_pend[5])
        else $error("capture pair not on shared vector");

    usb_persist_a: assert property (                            // [R12]
        src_event[34] |=> flags_r[34])
        else $error("usb flag not held");

    persist_level_a: assert property (                          // [R19]
        src_event[28] && reg_wr && reg_addr == `VISM_OFF_FLAGS_LOW
        |=> flags_r[28])
        else $error("persistent flag lost on clear");

    no_request_a: assert property (                             // [R18]
        (flags_r & enables_r) == 64'h0 |=> !core_irq)
        else $error("request with nothing pending");

    sequence two_pend_s;
        vec_pend[30] && vec_pend[31]
        && prio_r[7][20:16] == prio_r[7][28:24];
    endsequence

    tie_lower_a: assert property (                              // [R17]
        two_pend_s and (vec_pend[29:0] == 30'h0 && !vec_pend[32])
        |=> core_vector == 6'd30)
        else $error("tie not given to lower vector");

    flash_vec_a: assert property (                              // [R10]
        vec_pend == (33'h1 << 26) |=> core_vector == 6'd26
        && core_priority == $past(prio_r[6][20:18]))
        else $error("flash vector or priority wrong");

    timer_vec_a: assert property (                              // [R4]
        vec_pend == (33'h1 << 8) |=> core_vector == 6'd8)
        else $error("timer b vector wrong");

    compare_vec_a: assert property (                            // [R6]
        vec_pend == (33'h1 << 22) |=> core_vector == 6'd22)
        else $error("compare event e vector wrong");

    converter_vec_a: assert property (                          // [R7]
        vec_pend == (33'h1 << 23) |=> core_vector == 6'd23)
        else $error("converter vector wrong");

    clock_fail_a: assert property (                             // [R8]
        flags_r[29] && enables_r[29] |-> vec_pend[24])
        else $error("clock fail monitor not on vector 24");

    calendar_vec_a: assert property (                           // [R9]
        flags_r[30] && enables_r[30] |-> vec_pend[25])
        else $error("calendar clock not on vector 25");

    comparator_vec_a: assert property (                         // [R11]
        flags_r[33] && enables_r[33] |-> vec_pend[28])
        else $error("comparator b not on vector 28");

    serial_share_a: assert property (                           // [R13]
        |(flags_r[37:35] & enables_r[37:35]) |-> vec_pend[30])
        else $error("serial port requests not on vector 30");

    async_share_a: assert property (                            // [R14]
        |(flags_r[40:38] & enables_r[40:38]) |-> vec_pend[31])
        else $error("async port requests not on vector 31");

    wire_share_a: assert property (                             // [R15]
        |(flags_r[43:41] & enables_r[43:41]) |-> vec_pend[32])
        else $error("two-wire requests not on vector 32");

    sequence tick_rise_s;
        !src_event[0] ##1 src_event[0];
    endsequence

    tick_edge_a: assert property (                              // [R1]
        tick_rise_s |=> flags_r[0])
        else $error("core tick edge not flagged");

    sequence enable_write_s;
        reg_wr && reg_addr == `VISM_OFF_ENABLES_LOW;
    endsequence

    enable_store_a: assert property (                           // [R20]
        enable_write_s |=> enables_r[31:0] == $past(reg_wdata))
        else $error("enable write not stored");

    prio_store_a: assert property (                             // [R16]
        reg_wr && reg_addr == `VISM_OFF_PRIO_BASE
        |=> prio_r[0] == ($past(reg_wdata) & 32'h1f1f_1f1f))
        else $error("priority write not stored");

    read_idle_a: assert property (                              // [R20]
        !reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside read cycle");

endmodule // vism_core

`default_nettype wire

//--- include/vism_map.svh
`ifndef VISM_MAP_SVH
`define VISM_MAP_SVH

// ****************************************************************
// Register offsets (byte addresses, one word each)
// ****************************************************************
`define VISM_OFF_FLAGS_LOW    8'h00
`define VISM_OFF_FLAGS_HIGH   8'h04
`define VISM_OFF_ENABLES_LOW  8'h08
`define VISM_OFF_ENABLES_HIGH 8'h0c
`define VISM_OFF_PRIO_BASE    8'h10
`define VISM_OFF_PRIO_LAST    8'h30
`define VISM_OFF_STATUS       8'h34

// ****************************************************************
// Sizes and reset values
// ****************************************************************
`define VISM_NUM_SRC      44
`define VISM_NUM_VEC      33
`define VISM_NUM_PRIO_REG 9
`define VISM_HIGH_BITS    12
`define VISM_FLAGS_RST    32'h0000_0000
`define VISM_ENABLES_RST  32'h0000_0000
`define VISM_PRIO_RST     32'h0000_0000

// ****************************************************************
// Priority field layout inside a vector slot of 8 bits
// ****************************************************************
`define VISM_SLOT_W    8
`define VISM_PRI_LSB   2
`define VISM_SUB_LSB   0

`endif

//--- include/vism_pkg.sv
package vism_pkg;

    typedef struct packed {
        logic       req;
        logic [5:0] vec;
        logic [2:0] pri;
        logic [1:0] sub;
    } vism_req_s;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } vism_bus_s;

endpackage

//--- sim/vism_src_model.sv
`timescale 1ns/100ps
`default_nettype none

module vism_src_model (
    input  wire logic        ref_clk,
    input  wire logic [5:0]  sel,
    input  wire logic        fire,
    input  wire logic        hold,
    output var  logic [43:0] src_event
);
    // One-cycle pulse on the chosen source, kept as a level while held
    always_ff @(posedge ref_clk)
    begin
        if (fire)
            src_event <= 44'h000_0000_0001 << sel;
        else if (!hold)
            src_event <= 44'h000_0000_0000;
    end
endmodule // vism_src_model

`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "vism_map.svh"

module testbench;
    logic        ref_clk;
    logic        reset_n;
    logic        reg_wr;
    logic        reg_rd;
    logic        fire;
    logic        hold;
    logic        core_irq;
    logic [7:0]  reg_addr;
    logic [7:0]  ad;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic [31:0] d;
    logic [31:0] e;
    logic [31:0] v;
    logic [5:0]  sel;
    logic [5:0]  core_vector;
    logic [2:0]  core_priority;
    logic [2:0]  p;
    logic [1:0]  core_subpriority;
    logic [1:0]  s;
    logic [43:0] src_event;
    integer      fail_count;
    integer      samples_checked;
    integer      seed;
    integer      n;
    integer      i;
    integer      j;
    integer      a;
    integer      b;

    vism_core u_vism_core (
        .ref_clk          (ref_clk),
        .reset_n          (reset_n),
        .src_event        (src_event),
        .reg_addr         (reg_addr),
        .reg_wdata        (reg_wdata),
        .reg_wr           (reg_wr),
        .reg_rd           (reg_rd),
        .reg_rdata        (reg_rdata),
        .core_irq         (core_irq),
        .core_vector      (core_vector),
        .core_priority    (core_priority),
        .core_subpriority (core_subpriority)
    );

    vism_src_model u_vism_src_model (
        .ref_clk   (ref_clk),
        .sel       (sel),
        .fire      (fire),
        .hold      (hold),
        .src_event (src_event)
    );

    // ****************************************************************
    // Bus tasks and expectations
    // ****************************************************************
    task automatic wr(input logic [7:0] a_, input logic [31:0] v_);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a_;
        reg_wdata <= v_;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a_, output logic [31:0] v_);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a_;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 v_ = reg_rdata;
    endtask

    task automatic settle();
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            fail_count = fail_count + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [5:0] vec_of(input integer m);
        integer r;
        r = (m - 3) % 5;
        if (m < 3)
            return 6'(m);
        if (m < 28)
            return 6'(3 + 4 * ((m - 3) / 5) + ((r < 2) ? r : (r < 4) ? 2 : 3));
        if (m < 35)
            return 6'(m - 5);
        return (m < 38) ? 6'h1e : (m < 41) ? 6'h1f : 6'h20;
    endfunction

    function automatic logic pers(input integer m);
        return (m > 4 && m < 27 && ((m - 3) % 5 == 2 || (m - 3) % 5 == 3))
            || m == 28 || m > 33;
    endfunction

    function automatic logic [7:0] padr(input logic [5:0] w);
        return `VISM_OFF_PRIO_BASE + {w[5:2], 2'b00};
    endfunction

    function automatic logic [7:0] fadr(input integer m);
        return (m < 32) ? `VISM_OFF_FLAGS_LOW : `VISM_OFF_FLAGS_HIGH;
    endfunction

    function automatic logic [31:0] msk(input logic [7:0] a_);
        if (a_ >= `VISM_OFF_PRIO_BASE)
            return 32'h1f1f_1f1f;
        return a_[2] ? 32'h0000_0fff : 32'hffff_ffff;
    endfunction

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ****************************************************************
    // Clock, watchdog and main sequence
    // ****************************************************************
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    initial
    begin
        repeat (100000) @(posedge ref_clk);
        fail_count = fail_count + 1;
        print_verdict();
    end

    initial
    begin
        seed = 29540;
        fail_count = 0;
        samples_checked = 0;
        reset_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        fire = 1'b0;
        hold = 1'b0;
        sel = 6'h00;
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        for (i = 0; i < 14; i++)
        begin
            rd(8'(4 * i), d);
            chk(d, 32'h0000_0000);
        end
        rd(8'hfc, d);
        chk(d, 32'h0000_0000);
        for (i = 0; i < 13; i++)
        begin
            ad = 8'(4 * i);
            v = $random(seed);
            wr(ad, v);
            rd(ad, d);
            chk(d, v & msk(ad));
        end
        $display("test registers done");
        wr(`VISM_OFF_ENABLES_LOW, 32'hffff_ffff);
        wr(`VISM_OFF_ENABLES_HIGH, 32'h0000_0fff);
        for (n = 0; n < 44; n++)
        begin
            p = 3'($random(seed));
            s = 2'($random(seed));
            wr(padr(vec_of(n)), {4{3'h0, p, s}});
            wr(`VISM_OFF_FLAGS_LOW, 32'h0000_0000);
            wr(`VISM_OFF_FLAGS_HIGH, 32'h0000_0000);
            @(posedge ref_clk);
            sel <= 6'(n);
            fire <= 1'b1;
            hold <= pers(n);
            @(posedge ref_clk);
            fire <= 1'b0;
            settle();
            e = {20'h0, 1'b1, vec_of(n), p, s};
            chk({20'h0, core_irq, core_vector, core_priority,
                 core_subpriority}, e);
            rd(fadr(n), d);
            chk(d, 32'h1 << (n % 32));
            wr(fadr(n), 32'h0000_0000);
            rd(fadr(n), d);
            chk(d, pers(n) ? 32'h1 << (n % 32) : 32'h0);
            hold <= 1'b0;
            wr(`VISM_OFF_FLAGS_LOW, 32'h0000_0000);
            wr(`VISM_OFF_FLAGS_HIGH, 32'h0000_0000);
            settle();
            chk({31'h0, core_irq}, 32'h0);
        end
        $display("test mapping done");
        for (i = 0; i < 8; i++)
        begin
            a = {$random(seed)} % 32;
            b = {$random(seed)} % 32;
            if (vec_of(a) == vec_of(b))
                b = (a + 5) % 32;
            for (j = 0; j < 9; j++)
                wr(8'(16 + 4 * j), 32'h0000_0000);
            wr(`VISM_OFF_FLAGS_LOW, (32'h1 << a) | (32'h1 << b));
            settle();
            e = (vec_of(a) < vec_of(b)) ? a : b;
            chk({26'h0, core_vector}, {26'h0, vec_of(e)});
            v = 32'h1c << (8 * (vec_of(b) % 4));
            wr(padr(vec_of(b)), v);
            settle();
            chk({23'h0, core_vector, core_priority},
                {23'h0, vec_of(b), 3'h7});
            wr(`VISM_OFF_ENABLES_LOW, ~(32'h1 << b));
            settle();
            chk({26'h0, core_vector}, {26'h0, vec_of(a)});
            wr(`VISM_OFF_ENABLES_LOW, 32'hffff_ffff);
        end
        wr(`VISM_OFF_FLAGS_LOW, 32'h0000_0000);
        wr(padr(6'h1e), 32'h0a0a_0000);
        wr(`VISM_OFF_FLAGS_HIGH, 32'h0000_0048);
        settle();
        chk({26'h0, core_vector}, {26'h0, 6'h1e});
        rd(`VISM_OFF_STATUS, d);
        chk(d, {16'h0, 2'b01, 6'h1e, 3'h0, 3'h2, 2'h2});
        wr(`VISM_OFF_FLAGS_HIGH, 32'h0000_0000);
        wr(`VISM_OFF_ENABLES_LOW, 32'h0000_0000);
        settle();
        chk({31'h0, core_irq}, 32'h0);
        $display("test priority done");
        print_verdict();
    end
endmodule // testbench

`default_nettype wire
